/* File: dv/ebrw_partner.sv */
// Purpose: Model of the external device that answers bus cycles on the ready pin
// Assumes: Strobes are active low; ready is active low and pulled high when released
// Notes: delay counts falling edges of the clock output before ready goes low
`timescale 1ns/1ps
`default_nettype none
module ebrw_partner (
  input wire logic link_clk,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic clk_out,
  input wire logic [3:0] delay,
  output logic ready_n
);
  logic [3:0] cnt;
  logic clk_out_q;

  initial begin
    ready_n = 1'b1;
    cnt = 4'h0;
    clk_out_q = 1'b0;
  end

  // Answer after delay clock periods; a slow device makes the controller wait
  always @(posedge link_clk) begin
    clk_out_q <= clk_out;
    if (rd_n && wr_n) begin
      cnt <= 4'h0;
      ready_n <= 1'b1; // Released on strobe rise, well before the next cycle
    end else begin
      if (clk_out_q && !clk_out && cnt != 4'hF) cnt <= cnt + 4'h1;
      if (cnt >= delay) ready_n <= 1'b0; // Kept low until the strobe rises
    end
  end
endmodule // ebrw_partner
`default_nettype wire

/* File: dv/ext_bus_ready_waitstate_ctrl_tb.sv */
// Purpose: Self-checking bench of the bus cycle controller
// Assumes: Registers reached over AXI4-Lite; partner model answers on the ready pin
// Notes: Link clock unrelated in phase to the register clock
`timescale 1ns/1ps
`default_nettype none
`include "ebrw_consts.svh"
module ext_bus_ready_waitstate_ctrl_tb;
  logic aclk, aresetn, link_clk, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ready_n, clk_out, rd_n, wr_n, cyc_act;
  logic [3:0] awaddr, araddr, pdelay;
  logic [31:0] wdata, rdata, st, w0, w4;
  logic [1:0] bresp, rresp, r;
  logic rd_seen, wr_seen;
  int fails, n_checks, low_cnt, cycles;
  realtime t_end, t_done;
  realtime g [4];

  // ----------------------------------------
  // Clocks, design and partner
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  ebrw_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_clk(link_clk), .ext_ready_n(ready_n), .system_clock_output(clk_out),
    .ext_rd_n(rd_n), .ext_wr_n(wr_n), .bus_cycle_active(cyc_act));

  ebrw_partner partner (.link_clk(link_clk), .rd_n(rd_n), .wr_n(wr_n), .clk_out(clk_out),
    .delay(pdelay), .ready_n(ready_n));

  // Strobe width in link cycles, and the moment each cycle ends
  always @(posedge link_clk) begin
    if (!rd_n) begin
      low_cnt++;
      rd_seen = 1'b1;
    end
    if (!wr_n) begin
      low_cnt++;
      wr_seen = 1'b1;
    end
  end
  always @(negedge cyc_act) t_end = $realtime;

  // Hang guard: far above the thousand or so cycles the run needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    n_checks++;
    if (v !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        chk("rresp", 32'h0, {30'h0, rresp});
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Poll one status bit, bounded
  task automatic poll(input int b);
    st = 32'h0;
    for (int k = 0; k < 400 && st[b] !== 1'b1; k++) axi_rd(`EBRW_STAT_OFF, st);
    t_done = $realtime;
  endtask

  task automatic run_cycle(input logic wr);
    low_cnt = 0;
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    axi_wr(`EBRW_CMD_OFF, {30'h0, wr, 1'b1}, r);
    chk("cmd_resp", 32'h0, {30'h0, r});
    poll(1);
    chk("done", 32'h1, {31'h0, st[1]});
    axi_wr(`EBRW_STAT_OFF, 32'h0000_0002, r);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    axi_rd(`EBRW_CTRL_OFF, st);
    chk("ctrl_reset", 32'h0000_0100, st);
    chk("strobes_idle", 32'h3, {30'h0, rd_n, wr_n});
  endtask

  // Ready control off: strobe width is the programmed length less the delay
  task automatic t_len;
    int mc, dl;
    @(posedge link_clk);
    w0[0] = clk_out;
    @(posedge link_clk);
    chk("system_clock_output_toggle", {31'h0, ~w0[0]}, {31'h0, clk_out});
    for (int i = 0; i < 4; i++) begin
      mc = i[1] ? 3 : 0;
      dl = i[0];
      axi_wr(`EBRW_CTRL_OFF, 32'(mc + dl * 16), r);
      run_cycle(1'b0);
      chk("strobe_len", 32'(2 * (1 + mc) - dl), 32'(low_cnt));
      chk("read_strobe", 32'h2, {30'h0, rd_seen, wr_seen});
    end
  endtask

  // Slow answer adds waitstates; asynchronous mode also ends the cycle
  task automatic t_ready;
    axi_wr(`EBRW_CTRL_OFF, 32'h0000_0100, r);
    pdelay <= 4'h0;
    run_cycle(1'b1);
    chk("write_strobe", 32'h1, {30'h0, rd_seen, wr_seen});
    axi_rd(`EBRW_WCNT_OFF, w0);
    chk("sync_waits", 32'h1, w0);
    pdelay <= 4'h4;
    run_cycle(1'b0);
    axi_rd(`EBRW_WCNT_OFF, w4);
    chk("more_waits", 32'h1, {31'h0, w4 > w0});
    axi_wr(`EBRW_CTRL_OFF, 32'h0000_0180, r);
    pdelay <= 4'h2;
    run_cycle(1'b0);
    axi_rd(`EBRW_WCNT_OFF, w0);
    chk("async_waits", 32'h1, {31'h0, w0 != 32'h0});
  endtask

  // Gap after the cycle grows with multiplexing and the tristate waitstate
  task automatic t_gap;
    for (int i = 0; i < 4; i++) begin
      axi_wr(`EBRW_CTRL_OFF, 32'(i * 32), r);
      run_cycle(1'b0);
      g[i] = t_done - t_end;
    end
    chk("mux_gap", 32'h1, {31'h0, g[1] > g[0]});
    chk("tri_gap", 32'h1, {31'h0, g[3] > g[0] + 200.0});
  endtask

  // Writes refused while a long cycle runs
  task automatic t_refuse;
    axi_wr(`EBRW_CTRL_OFF, 32'h0000_0100, r);
    pdelay <= 4'hF;
    axi_wr(`EBRW_CMD_OFF, 32'h0000_0001, r);
    poll(0);
    axi_wr(`EBRW_CTRL_OFF, 32'h0000_0000, r);
    chk("ctrl_busy_resp", 32'h2, {30'h0, r});
    axi_wr(`EBRW_WCNT_OFF, 32'h0000_0000, r);
    chk("wcnt_resp", 32'h2, {30'h0, r});
    axi_rd(`EBRW_CTRL_OFF, st);
    chk("ctrl_kept", 32'h0000_0100, st);
    poll(1);
    chk("slow_done", 32'h1, {31'h0, st[1]});
  endtask

  task automatic end_of_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Reset long enough for the link domain, then the scenarios
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    pdelay = 4'h0;
    aresetn = 1'b0;
    repeat (4) @(posedge link_clk);
    @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    repeat (4) @(posedge link_clk);
    t_len();
    t_ready();
    t_gap();
    t_refuse();
    end_of_test();
  end
endmodule // ext_bus_ready_waitstate_ctrl_tb
`default_nettype wire

/* File: logic/ebrw_consts.svh */
// Purpose: Offsets, field positions and reset values of the bus cycle controller
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef EBRW_CONSTS_SVH
`define EBRW_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EBRW_CTRL_OFF 4'h0
`define EBRW_CMD_OFF 4'h4
`define EBRW_STAT_OFF 4'h8
`define EBRW_WCNT_OFF 4'hC

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EBRW_CTRL_MEMORY_CYCLE_TIME_WAITSTATES_LSB 0
`define EBRW_CTRL_RWDLY 4
`define EBRW_CTRL_MUX 5
`define EBRW_CTRL_TRI 6
`define EBRW_CTRL_ASYNC 7
`define EBRW_CTRL_RDYEN 8
`define EBRW_CMD_START 0
`define EBRW_CMD_WRITE 1
`define EBRW_STAT_BUSY 0
`define EBRW_STAT_DONE 1

// ----------------------------------------
// Reset values and responses
// ----------------------------------------
`define EBRW_CTRL_RST 9'h100
`define EBRW_RESP_OKAY 2'h0
`define EBRW_RESP_SLVERR 2'h2

`endif

/* File: logic/ebrw_ctrl.sv */
// Purpose: External bus cycle pacing with waitstates and a ready handshake
// Assumes: link_clk runs free; it is the CPU clock of the external bus
// Notes: One link_clk cycle is one clock phase; clock output is link_clk / 2
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ebrw_consts.svh"
module ebrw_ctrl import ebrw_pkg::*; #(
  parameter int MEMORY_CYCLE_TIME_WAITSTATES_W = 4,
  parameter int WCNT_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk,
  input wire logic ext_ready_n,
  output logic system_clock_output,
  output logic ext_rd_n,
  output logic ext_wr_n,
  output logic bus_cycle_active
);
  // Control word width follows the field map; the cycle count must stay below the delay bit
  localparam int CW = `EBRW_CTRL_RDYEN + 1;

  if (MEMORY_CYCLE_TIME_WAITSTATES_W < 1 || MEMORY_CYCLE_TIME_WAITSTATES_W > `EBRW_CTRL_RWDLY || WCNT_W < 1 || WCNT_W > 32) begin : g_chk
    $error("ebrw_ctrl: MEMORY_CYCLE_TIME_WAITSTATES_W must be 1..4 and WCNT_W 1..32");
  end

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  // Returns {hit, index}; addresses are word aligned
  function automatic logic [2:0] reg_sel(input logic [3:0] a);
    reg_sel = {1'b1, a[3:2]};
  endfunction

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q;
  logic [3:0] aw_addr_q, w_strb_q;
  logic [31:0] w_data_q, rdata_q;
  ebrw_resp_t bresp_q, rresp_q;
  logic [CW-1:0] ctrl_q;
  logic cmd_wr_q, busy_q, done_q, start_tgl_q, done_seen_q, start_go_q;
  logic [WCNT_W-1:0] wcnt_a_q;
  logic [WCNT_W:0] back_s;
  logic wr_fire, start_req;
  logic [2:0] wsel, rsel;

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wsel = reg_sel(aw_addr_q);
  assign rsel = reg_sel(s_axi_araddr);
  assign start_req = wr_fire && wsel[1:0] == `EBRW_CMD_OFF >> 2 && w_strb_q[0] &&
                     w_data_q[`EBRW_CMD_START] && !busy_q;

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  // Address and data are taken independently; the write is done once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
      aw_addr_q <= 4'h0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_have_q <= 1'b1;
      awready_q <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  // Write data holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      w_have_q <= 1'b1;
      wready_q <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  // Response; control writes while a cycle runs are refused so the link sees a stable word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `EBRW_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wsel[1:0] == `EBRW_WCNT_OFF >> 2 ||
                  (wsel[1:0] == `EBRW_CTRL_OFF >> 2 && busy_q)) ?
                 `EBRW_RESP_SLVERR : `EBRW_RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Control register, byte lanes 0 and 1 hold the fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CW'(`EBRW_CTRL_RST);
      cmd_wr_q <= 1'b0;
    end else if (wr_fire && wsel[1:0] == `EBRW_CTRL_OFF >> 2 && !busy_q) begin
      for (int i = 0; i < CW; i++) begin
        if (w_strb_q[i/8]) begin
          ctrl_q[i] <= w_data_q[i];
        end
      end
    end else if (start_req) begin
      cmd_wr_q <= w_data_q[`EBRW_CMD_WRITE];
    end
  end

  // Busy, sticky done (set wins over clear), start toggle to the link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      start_tgl_q <= 1'b0;
      done_seen_q <= 1'b0;
      start_go_q <= 1'b0;
      wcnt_a_q <= '0;
    end else begin
      done_seen_q <= back_s[WCNT_W];
      // Toggle a cycle after the command bit moves, so that bit is settled at the link first
      start_go_q <= start_req;
      if (start_go_q) begin
        start_tgl_q <= ~start_tgl_q;
      end
      if (start_req) begin
        busy_q <= 1'b1;
      end else if (back_s[WCNT_W] != done_seen_q) begin
        busy_q <= 1'b0;
        wcnt_a_q <= back_s[WCNT_W-1:0];
      end
      if (back_s[WCNT_W] != done_seen_q) begin
        done_q <= 1'b1;
      end else if (wr_fire && wsel[1:0] == `EBRW_STAT_OFF >> 2 && w_strb_q[0] &&
                   w_data_q[`EBRW_STAT_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------
  // One read in flight; data answered the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `EBRW_RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= rsel[2] ? `EBRW_RESP_OKAY : `EBRW_RESP_SLVERR;
      case (rsel[1:0])
        2'h0: rdata_q <= 32'(ctrl_q);
        2'h1: rdata_q <= 32'(cmd_wr_q) << `EBRW_CMD_WRITE;
        2'h2: rdata_q <= {30'h0, done_q, busy_q};
        default: rdata_q <= 32'(wcnt_a_q);
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // Domain crossings
  // ----------------------------------------
  logic link_rst_n, rdy_s2, rdy_s3, rdy_flt_q, system_clock_output_q, start_seen_q, done_tgl_q;
  logic [CW+1:0] fwd_s;
  logic [WCNT_W-1:0] wcnt_l_q;

  ebrw_sync #(.W(1), .STAGES(2)) u_rst_sync (
    .clk(link_clk), .rst_n(1'b1), .d(aresetn), .q(link_rst_n));
  // Config is stable while busy, so it settles before the start toggle arrives
  ebrw_sync #(.W(CW+2), .STAGES(2)) u_fwd_sync (
    .clk(link_clk), .rst_n(link_rst_n), .d({start_tgl_q, cmd_wr_q, ctrl_q}), .q(fwd_s));
  ebrw_sync #(.W(WCNT_W+1), .STAGES(2)) u_back_sync (
    .clk(aclk), .rst_n(aresetn), .d({done_tgl_q, wcnt_l_q}), .q(back_s));
  ebrw_sync #(.W(1), .STAGES(2)) u_rdy_sync (
    .clk(link_clk), .rst_n(link_rst_n), .d(ext_ready_n), .q(rdy_s2));

  // Third stage and agreement filter on the ready pin
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      rdy_s3 <= 1'b1;
      rdy_flt_q <= 1'b1;
    end else begin
      rdy_s3 <= rdy_s2;
      if (rdy_s2 == rdy_s3) begin
        rdy_flt_q <= rdy_s3;
      end
    end
  end

  // ----------------------------------------
  // Link side cycle sequencer
  // ----------------------------------------
  ebrw_state_e state_q;
  logic [CW-1:0] cfg_q;
  logic cfg_wr_q, cycle_q, rd_n_q, wr_n_q, step, start_pend, rdy_n_use, strobe_on, was_idle_q;
  logic [MEMORY_CYCLE_TIME_WAITSTATES_W-1:0] cnt_q;
  logic [MEMORY_CYCLE_TIME_WAITSTATES_W-1:0] memory_cycle_time_waitstates;
  logic rwdly, muxed, tri_en, async_rdy, rdy_en;
  ebrw_state_e gap_state;

  assign memory_cycle_time_waitstates = cfg_q[`EBRW_CTRL_MEMORY_CYCLE_TIME_WAITSTATES_LSB +: MEMORY_CYCLE_TIME_WAITSTATES_W];
  assign rwdly = cfg_q[`EBRW_CTRL_RWDLY];
  assign muxed = cfg_q[`EBRW_CTRL_MUX];
  assign tri_en = cfg_q[`EBRW_CTRL_TRI];
  assign async_rdy = cfg_q[`EBRW_CTRL_ASYNC];
  assign rdy_en = cfg_q[`EBRW_CTRL_RDYEN];
  // Sampling points fall on the clock output's falling edge
  assign step = system_clock_output_q;
  assign start_pend = fwd_s[CW+1] != start_seen_q;
  // Sync ready skips the third stage and agreement filter to save two phases of latency
  assign rdy_n_use = async_rdy ? rdy_flt_q : rdy_s2;
  assign strobe_on = !rd_n_q || !wr_n_q;
  assign gap_state = muxed ? EBRW_TURN : (tri_en ? EBRW_TRIW : EBRW_IDLE);

  // Clock output is a free toggle; a period is two phases
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      system_clock_output_q <= 1'b0;
    end else begin
      system_clock_output_q <= ~system_clock_output_q;
    end
  end

  // State, counters and strobes
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      state_q <= EBRW_IDLE;
      cfg_q <= CW'(`EBRW_CTRL_RST);
      cfg_wr_q <= 1'b0;
      cnt_q <= '0;
      wcnt_l_q <= '0;
      cycle_q <= 1'b0;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      start_seen_q <= 1'b0;
      done_tgl_q <= 1'b0;
      was_idle_q <= 1'b1;
    end else begin
      case (state_q)
        EBRW_IDLE: begin
          if (step && start_pend) begin
            state_q <= EBRW_PROG;
            start_seen_q <= fwd_s[CW+1];
            cfg_q <= fwd_s[CW-1:0];
            cfg_wr_q <= fwd_s[CW];
            cnt_q <= '0;
            wcnt_l_q <= '0;
            cycle_q <= 1'b1;
            if (!fwd_s[`EBRW_CTRL_RWDLY]) begin
              rd_n_q <= fwd_s[CW];
              wr_n_q <= !fwd_s[CW];
            end
          end
        end
        EBRW_PROG: begin
          if (!step && !strobe_on) begin
            rd_n_q <= cfg_wr_q;
            wr_n_q <= !cfg_wr_q;
          end
          if (step) begin
            if (cnt_q != memory_cycle_time_waitstates) begin
              cnt_q <= cnt_q + 1'b1;
            end else if (!rdy_en || !rdy_n_use) begin
              state_q <= gap_state;
              cycle_q <= 1'b0;
              rd_n_q <= 1'b1;
              wr_n_q <= 1'b1;
            end else begin
              state_q <= EBRW_RDYW;
              wcnt_l_q <= wcnt_l_q + 1'b1; // First ready waitstate counts too
            end
          end
        end
        EBRW_RDYW: begin
          if (step) begin
            if (!rdy_n_use) begin
              state_q <= gap_state;
              cycle_q <= 1'b0;
              rd_n_q <= 1'b1;
              wr_n_q <= 1'b1;
            end else begin
              wcnt_l_q <= wcnt_l_q + 1'b1;
            end
          end
        end
        EBRW_TURN: begin
          if (step) begin
            state_q <= tri_en ? EBRW_TRIW : EBRW_IDLE;
          end
        end
        EBRW_TRIW: begin
          if (step) begin
            state_q <= EBRW_IDLE;
          end
        end
        default: state_q <= EBRW_IDLE;
      endcase
      // Report completion the edge after the gap ends; the count word has settled by then
      was_idle_q <= state_q == EBRW_IDLE;
      if (state_q == EBRW_IDLE && !was_idle_q) begin
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  assign system_clock_output = system_clock_output_q;
  assign ext_rd_n = rd_n_q;
  assign ext_wr_n = wr_n_q;
  assign bus_cycle_active = cycle_q;

  // ----------------------------------------
  // Assertions and covers
  // ----------------------------------------
  ready_wait_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    state_q == EBRW_RDYW && step && rdy_n_use |=> state_q == EBRW_RDYW && strobe_on)
    else $error("ready high did not add a waitstate");
  ready_end_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    state_q == EBRW_RDYW && step && !rdy_n_use |=> !cycle_q && rd_n_q && wr_n_q)
    else $error("ready low did not end the cycle");
  prog_len_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $fell(cycle_q) |-> $past(cnt_q) == $past(memory_cycle_time_waitstates))
    else $error("cycle ended before programmed length");
  cmd_delay_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $rose(cycle_q) |-> if (rwdly) (!strobe_on ##1 strobe_on) else strobe_on)
    else $error("strobe edge does not follow delay option");
  turn_wait_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $fell(cycle_q) && muxed |-> state_q == EBRW_TURN)
    else $error("muxed cycle without turnaround waitstate");
  gap_muxtri_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $fell(cycle_q) && muxed && tri_en |-> (state_q != EBRW_IDLE)[*4] ##1 state_q == EBRW_IDLE)
    else $error("muxed gap with tristate is not two periods");
  gap_demux_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $fell(cycle_q) && !muxed && !tri_en |-> state_q == EBRW_IDLE)
    else $error("demuxed gap is not zero");
  next_start_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    state_q == EBRW_IDLE && step && start_pend |=> cycle_q)
    else $error("pending cycle did not start");
  ready_filt_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    $changed(rdy_flt_q) |-> $past(rdy_s2) == $past(rdy_s3))
    else $error("ready filter changed without agreement");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  ready_ws_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    state_q == EBRW_RDYW && step && rdy_n_use);
  mux_tri_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    state_q == EBRW_TRIW && muxed);
  rw_delay_c: cover property (@(posedge link_clk) disable iff (!link_rst_n)
    $rose(cycle_q) && rwdly);
endmodule // ebrw_ctrl
`default_nettype wire

/* File: logic/ebrw_pkg.sv */
// Purpose: Types shared by the bus cycle controller
// Assumes: Nothing
// Notes: Gray codes along idle, program, ready, turnaround, tristate
package ebrw_pkg;
  typedef enum logic [2:0] {
    EBRW_IDLE = 3'h0,
    EBRW_PROG = 3'h1,
    EBRW_RDYW = 3'h3,
    EBRW_TURN = 3'h2,
    EBRW_TRIW = 3'h6
  } ebrw_state_e;
  typedef logic [1:0] ebrw_resp_t;
endpackage

/* File: logic/ebrw_sync.sv */
// Purpose: Multi-flop synchroniser for levels and quasi-static words
// Assumes: Words change only while the receiver ignores them
// Notes: Only the last stage leaves the module
`timescale 1ns/1ps
`default_nettype none
module ebrw_sync #(
  parameter int W = 1,
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage_q [STAGES];

  // Refuse chains too short to settle metastability
  if (STAGES < 2) begin : g_chk
    $error("ebrw_sync needs at least two stages");
  end

  // Shift chain, cleared by synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= d;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign q = stage_q[STAGES-1];
endmodule // ebrw_sync
`default_nettype wire
